/* sdwp_pkg.sv */
// Package for the serial converter write port.
// Assumes a single 10-bit code field inside a 16-bit serial word.
package sdwp_pkg;
   localparam int unsigned FRAME_BITS   = 16;
   localparam int unsigned CODE_BITS    = 10;
   localparam int unsigned CODE_LSB     = 2;
   localparam int unsigned CNT_BITS     = 5;
   localparam int unsigned FIFO_DEPTH   = 8;
   localparam int unsigned LINK_MAX_MHZ = 30;
   localparam int unsigned REF_CLK_MHZ  = 25;

   localparam logic [4:0]  CNT_LAST     = 5'h0F;
   localparam logic [4:0]  CNT_DONE     = 5'h10;
   localparam logic [9:0]  CODE_RESET   = 10'h000;

   typedef logic [FRAME_BITS-1:0] sdwp_word_t;
   typedef logic [CODE_BITS-1:0]  sdwp_code_t;

   // Frame progress, cleared while frame sync is high
   typedef struct packed {
      logic [CNT_BITS-1:0] cnt;
      sdwp_word_t          shift;
   } sdwp_frame_t;

   // Completed word handed to the reference domain
   typedef struct packed {
      sdwp_word_t word;
      logic       tog;
   } sdwp_link_t;

   // Reference-domain state
   typedef struct packed {
      logic       tog_s1;
      logic       tog_s2;
      logic       tog_s3;
      logic       overflow;
      sdwp_code_t code;
   } sdwp_ref_t;

   // Serial link pins
   typedef struct packed {
      logic frame_sync_n;
      logic serial_data_in;
   } sdwp_pins_t;
endpackage

/* sdwp_fifo.sv */
// Small FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
module sdwp_fifo
#(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 8
)
(
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int unsigned AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr;
      logic [AW-1:0]               rd;
      logic [AW:0]                 fill;
   } sdwp_fifo_st_t;

   sdwp_fifo_st_t st_r;
   sdwp_fifo_st_t st_nxt;
   logic          push;
   logic          pop;

   assign in_ready  = (st_r.fill != DEPTH[AW:0]);
   assign out_valid = (st_r.fill != '0);
   assign out_data  = st_r.mem[st_r.rd];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb
   begin
      st_nxt = st_r;
      if (push)
      begin
         st_nxt.mem[st_r.wr] = in_data;
         st_nxt.wr           = (st_r.wr == AW'(DEPTH - 1)) ? '0 : st_r.wr + 1'b1;
      end
      if (pop)
      begin
         st_nxt.rd = (st_r.rd == AW'(DEPTH - 1)) ? '0 : st_r.rd + 1'b1;
      end
      if (push && !pop)
      begin
         st_nxt.fill = st_r.fill + 1'b1;
      end
      else if (pop && !push)
      begin
         st_nxt.fill = st_r.fill - 1'b1;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end
endmodule

/* sdwp_write_port.sv */
// Write port of a 10-bit converter: three-wire serial link in, code out.
// Assumes the host clocks frames on the shift clock and ref_clk runs free.
`timescale 1ns/100ps
module sdwp_write_port
(
   // Reference clock and reset
   input  wire logic               ref_clk,
   input  wire logic               rst_n,
   // Serial link
   input  wire logic               shift_clk,
   input  wire sdwp_pkg::sdwp_pins_t link_pins,
   // Converter side
   input  wire logic               update_ready,
   output sdwp_pkg::sdwp_code_t    analog_output,
   output logic                    word_pending,
   output logic                    link_ready,
   output logic                    overflow
);
   import sdwp_pkg::*;

   // Link-domain state
   sdwp_frame_t frm_r;
   sdwp_frame_t frm_nxt;
   sdwp_link_t  lnk_r;
   sdwp_link_t  lnk_nxt;
   // Reference-domain state
   sdwp_ref_t   ref_r;
   sdwp_ref_t   ref_nxt;
   // Link-domain decode
   logic        frame_open;
   logic        frame_more;
   logic        frame_last;
   sdwp_word_t  frame_word;
   // Reference-domain decode
   logic        word_arrived;
   logic        word_drop;
   logic        code_load;
   sdwp_code_t  code_field;
   // FIFO side
   logic        fifo_in_valid;
   logic        fifo_in_ready;
   sdwp_word_t  fifo_in_data;
   logic        fifo_out_valid;
   logic        fifo_out_ready;
   sdwp_word_t  fifo_out_data;

   assign frame_open = !link_pins.frame_sync_n;
   assign frame_more = (frm_r.cnt != CNT_DONE);
   assign frame_last = (frm_r.cnt == CNT_LAST);
   assign frame_word = {frm_r.shift[FRAME_BITS-2:0], link_pins.serial_data_in};

   // Link domain: shift register and frame counter
   always_comb
   begin
      frm_nxt = frm_r;
      if (frame_more)
      begin
         frm_nxt.shift = frame_word;
         frm_nxt.cnt   = frm_r.cnt + 1'b1;
      end
   end

   // Link domain: completed word and toggle
   always_comb
   begin
      lnk_nxt = lnk_r;
      if (frame_last)
      begin
         lnk_nxt.word = frame_word;
         lnk_nxt.tog  = ~lnk_r.tog;
      end
   end

   // frame sync high holds shifter cleared
   always_ff @(negedge shift_clk or posedge link_pins.frame_sync_n)
   begin
      if (link_pins.frame_sync_n)
      begin
         frm_r <= '0;
      end
      else
      begin
         frm_r <= frm_nxt;
      end
   end

   always_ff @(negedge shift_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lnk_r <= '0;
      end
      else if (frame_open)
      begin
         lnk_r <= lnk_nxt;
      end
   end

   // Reference domain: toggle crossing
   // Only the second and third stages feed logic
   assign word_arrived = ref_r.tog_s2 ^ ref_r.tog_s3;
   // Full FIFO drops the new word
   assign word_drop    = word_arrived && !fifo_in_ready;
   assign code_field   = fifo_out_data[CODE_LSB +: CODE_BITS];
   assign code_load    = fifo_out_valid && fifo_out_ready;

   // Word stays stable from toggle to next frame
   assign fifo_in_valid  = word_arrived;
   assign fifo_in_data   = lnk_r.word;
   assign fifo_out_ready = update_ready;

   sdwp_fifo
   #(
      .WIDTH (FRAME_BITS),
      .DEPTH (FIFO_DEPTH)
   )
   u_fifo
   (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (fifo_in_data),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data)
   );

   // Converter side outputs
   assign analog_output = ref_r.code;
   assign overflow      = ref_r.overflow;
   assign word_pending  = fifo_out_valid;
   assign link_ready    = fifo_in_ready;

   // Reference domain: code update
   always_comb
   begin
      ref_nxt          = ref_r;
      ref_nxt.tog_s1   = lnk_r.tog;
      ref_nxt.tog_s2   = ref_r.tog_s1;
      ref_nxt.tog_s3   = ref_r.tog_s2;
      ref_nxt.overflow = word_drop;
      if (code_load)
      begin
         ref_nxt.code = code_field;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         ref_r      <= '0;
         ref_r.code <= CODE_RESET;
      end
      else
      begin
         ref_r <= ref_nxt;
      end
   end
endmodule

/* sdwp_asserts.sv */
// Checker for the write port.
// Assumes a bind to the top module.
`timescale 1ns/100ps
module sdwp_asserts
(
   // Watched ports
   input wire logic                 ref_clk,
   input wire logic                 rst_n,
   input wire sdwp_pkg::sdwp_pins_t link_pins,
   input wire logic                 update_ready,
   input wire sdwp_pkg::sdwp_code_t analog_output,
   input wire logic                 word_pending,
   input wire logic                 link_ready,
   input wire logic                 overflow
);
   import sdwp_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   AST_RST_ZERO: assert property ($rose(rst_n) |-> analog_output == CODE_RESET)
      else $error("code not zero");
   AST_IDLE: assert property (link_pins.frame_sync_n [*6] |-> !$rose(word_pending))
      else $error("word while idle");
   AST_STALL: assert property (!update_ready |=> $stable(analog_output))
      else $error("code moved");
   AST_SRC: assert property (!$stable(analog_output) |-> $past(word_pending))
      else $error("code without word");
   AST_OVF: assert property (overflow |-> !$past(link_ready))
      else $error("bad overflow");
   AST_FULL: assert property (!link_ready |-> word_pending)
      else $error("full but empty");
endmodule

/* sdwp_host.sv */
// Host serial master model.
// Assumes the bench calls send; clock idles high.
`timescale 1ns/100ps
module sdwp_host
(
   // Link outputs
   output logic                 shift_clk,
   output sdwp_pkg::sdwp_pins_t link_pins
);
   import sdwp_pkg::*;
   initial
   begin
      shift_clk = 1'b1;
      link_pins = 2'h3;
   end
   task automatic send(input sdwp_word_t w, input int n);
      for (int i = 0; i < n; i++)
      begin
         link_pins.serial_data_in = w[15-i];
         link_pins.frame_sync_n = 1'b0;
         #16 shift_clk = 1'b0;
         #16 shift_clk = 1'b1;
      end
      #16 link_pins = {1'b1, ~link_pins.serial_data_in};
   endtask
endmodule

/* sdwp_write_port_tb.sv */
// Testbench for the write port.
// Assumes host model and checker compiled first.
`timescale 1ns/100ps
module sdwp_write_port_tb;
   import sdwp_pkg::*;
   logic        ref_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        update_ready = 1'b1;
   logic        shift_clk;
   sdwp_pins_t  link_pins;
   sdwp_code_t  analog_output;
   sdwp_code_t  last_c = 10'h000;
   sdwp_code_t  prev_c = 10'h000;
   logic        word_pending;
   logic        link_ready;
   logic        overflow;
   logic [31:0] seed = 32'h0001_5CF1;
   int          err_total = 0;
   int          total_checks = 0;
   int          ovf_seen = 0;
   sdwp_code_t  q[$];
   initial forever #20 ref_clk = ~ref_clk;
   sdwp_host sdwp_host_inst (.shift_clk, .link_pins);
   sdwp_write_port sdwp_write_port_inst (.ref_clk, .rst_n, .shift_clk, .link_pins,
      .update_ready, .analog_output, .word_pending, .link_ready, .overflow);
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      v = v ^ (v << 5);
      return v;
   endfunction
   task automatic frame(input int n, input bit push);
      sdwp_word_t w;
      seed = xs(seed);
      w = seed[15:0];
      if (push && w[11:2] !== last_c)
      begin
         q.push_back(w[11:2]);
         last_c = w[11:2];
      end
      sdwp_host_inst.send(w, n);
      #200;
   endtask
   always @(negedge ref_clk)
   begin
      if (rst_n && analog_output !== prev_c)
         chk(analog_output, q.size() ? q.pop_front() : ~analog_output);
      if (overflow === 1'b1)
         ovf_seen++;
      prev_c <= analog_output;
   end
   initial
   begin
      repeat (2) @(negedge ref_clk);
      rst_n = 1'b1;
      chk(analog_output, CODE_RESET);
      frame(9, 1'b0);
      chk(analog_output, CODE_RESET);
      repeat (4) frame(16, 1'b1);
      frame(9, 1'b0);
      @(negedge ref_clk) update_ready = 1'b0;
      repeat (8) frame(16, 1'b1);
      chk(link_ready, 1'b0);
      frame(16, 1'b0);
      @(negedge ref_clk) update_ready = 1'b1;
      for (int i = 0; i < 50 && word_pending; i++) @(negedge ref_clk);
      repeat (2) @(negedge ref_clk);
      chk(word_pending, 1'b0);
      chk(16'(q.size()), 16'h0000);
      chk(16'(ovf_seen), 16'h0001);
      end_sim();
   end
endmodule
bind sdwp_write_port sdwp_asserts sdwp_asserts_inst (.ref_clk, .rst_n, .link_pins,
   .update_ready, .analog_output, .word_pending, .link_ready, .overflow);
